// ### design/mcr_top.sv
// Miscellaneous configuration register bank with its control outputs
`timescale 1ns/1ps
module mcr_top (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata_q, // Read data, one cycle after strobe
  output logic access_refused_q, // Pulse: address outside selected page
  output logic page_sel_q, // Lower page selected
  input wire logic all_idle, // Every function waiting or disabled
  output logic low_power_q, // Reduced-power state
  input wire logic [7:0] wait_time, // Programmed wait time
  output logic [11:0] wait_cycles_q, // Effective wait time
  input wire logic irq_pending, // Any interrupt pending
  input wire logic irq_sleep_clr, // Pulse: host clears sleep flag
  output logic irq_sleep_flag_q, // Sleeping because of interrupt
  output logic osc_run_q, // Oscillator enable
  input wire logic matrix_command_trigger, // Trigger level from host
  output logic cmd_rom_init_q, // Pulse: start ROM init
  output logic cmd_read_chain_q, // Pulse: start chain read
  output logic cmd_write_chain_q, // Pulse: start chain write
  input wire logic matrix_done, // Pulse: matrix command finished
  input wire logic [7:0] flicker_status, // Flicker-detection status
  output logic sys_irq_q // Pulse: system interrupt request
);

  // Address lies in the lower page
  function automatic logic in_lower(input logic [7:0] a);
    in_lower = (a >= mcr_pkg::LOWER_PAGE_FIRST) && (a <= mcr_pkg::LOWER_PAGE_LAST);
  endfunction : in_lower

  // Access reaches the bank given the page bit; page control always reachable
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic pg);
    hit = (a == ofs) && (!pg || ofs == mcr_pkg::POWER_AND_PAGE_CONFIG_OFS);
  endfunction : hit

  logic low_power_en_q;
  logic wait_stretch_q;
  logic sleep_on_irq_q;
  logic flicker_irq_enable_q;
  logic matrix_done_irq_enable_q;
  mcr_pkg::mcr_cmd_type matrix_cmd_q;
  logic trig_prev_q;
  logic [7:0] flicker_prev_q;
  logic trig_rise;
  logic flicker_change;
  logic refused;

  mcr_sleep_if sl ();

  always_comb begin
    trig_rise = matrix_command_trigger & ~trig_prev_q;
    flicker_change = flicker_status != flicker_prev_q;
    refused = (reg_wr | reg_rd)
      & ((page_sel_q & ~in_lower(reg_addr) & reg_addr != mcr_pkg::POWER_AND_PAGE_CONFIG_OFS)
      | (~page_sel_q & in_lower(reg_addr)));
  end

  // Power and page register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power_en_q <= 1'b0;
      page_sel_q <= 1'b0;
      wait_stretch_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, mcr_pkg::POWER_AND_PAGE_CONFIG_OFS, page_sel_q)) begin
      low_power_en_q <= reg_wdata[mcr_pkg::LOW_POWER_BIT];
      page_sel_q <= reg_wdata[mcr_pkg::PAGE_SEL_BIT];
      wait_stretch_q <= reg_wdata[mcr_pkg::WAIT_STRETCH_BIT];
    end
  end

  // Sleep config register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_on_irq_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, mcr_pkg::SLEEP_ON_IRQ_CONFIG_OFS, page_sel_q)) begin
      sleep_on_irq_q <= reg_wdata[mcr_pkg::SLEEP_ON_IRQ_BIT];
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flicker_irq_enable_q <= 1'b0;
      matrix_done_irq_enable_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, mcr_pkg::SYSTEM_IRQ_ENABLES_OFS, page_sel_q)) begin
      flicker_irq_enable_q <= reg_wdata[mcr_pkg::FLICKER_IRQ_EN_BIT];
      matrix_done_irq_enable_q <= reg_wdata[mcr_pkg::MATRIX_DONE_IRQ_EN_BIT];
    end
  end

  // Matrix command register, resets to write-chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      matrix_cmd_q <= mcr_pkg::mcr_cmd_type'(mcr_pkg::MATRIX_CMD_RESET);
    end else if (reg_wr && hit(reg_addr, mcr_pkg::MATRIX_COMMAND_CONFIG_OFS, page_sel_q)) begin
      matrix_cmd_q <= mcr_pkg::mcr_cmd_type'(
        reg_wdata[mcr_pkg::MATRIX_CMD_MSB:mcr_pkg::MATRIX_CMD_LSB]);
    end
  end

  // Read data and refusal pulse; reserved bits read as reset values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      access_refused_q <= 1'b0;
    end else begin
      access_refused_q <= refused;
      if (!reg_rd) begin
        reg_rdata_q <= 8'h00;
      end else if (hit(reg_addr, mcr_pkg::POWER_AND_PAGE_CONFIG_OFS, page_sel_q)) begin
        reg_rdata_q <= {2'b00, low_power_en_q, page_sel_q, 1'b0, wait_stretch_q, 2'b00};
      end else if (hit(reg_addr, mcr_pkg::SLEEP_ON_IRQ_CONFIG_OFS, page_sel_q)) begin
        reg_rdata_q <= {3'b000, sleep_on_irq_q, mcr_pkg::SLEEP_CFG_LOW_NIBBLE};
      end else if (hit(reg_addr, mcr_pkg::SYSTEM_IRQ_ENABLES_OFS, page_sel_q)) begin
        reg_rdata_q <= {1'b0, flicker_irq_enable_q, 1'b0, matrix_done_irq_enable_q, 4'h0};
      end else if (hit(reg_addr, mcr_pkg::MATRIX_COMMAND_CONFIG_OFS, page_sel_q)) begin
        reg_rdata_q <= {3'b000, matrix_cmd_q, 3'b000};
      end else begin
        reg_rdata_q <= 8'h00;
      end
    end
  end

  // Low-power state and stretched wait time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_power_q <= 1'b0;
      wait_cycles_q <= 12'h000;
    end else begin
      low_power_q <= low_power_en_q & all_idle;
      wait_cycles_q <= wait_stretch_q ? {wait_time, 4'h0} : {4'h0, wait_time};
    end
  end

  // Matrix command launch on trigger rise; reserved code ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_q <= 1'b0;
      cmd_rom_init_q <= 1'b0;
      cmd_read_chain_q <= 1'b0;
      cmd_write_chain_q <= 1'b0;
    end else begin
      trig_prev_q <= matrix_command_trigger;
      cmd_rom_init_q <= trig_rise && matrix_cmd_q == mcr_pkg::MCR_CMD_ROM_INIT;
      cmd_read_chain_q <= trig_rise && matrix_cmd_q == mcr_pkg::MCR_CMD_READ_CHAIN;
      cmd_write_chain_q <= trig_rise && matrix_cmd_q == mcr_pkg::MCR_CMD_WRITE_CHAIN;
    end
  end

  // System interrupt requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flicker_prev_q <= 8'h00;
      sys_irq_q <= 1'b0;
    end else begin
      flicker_prev_q <= flicker_status;
      sys_irq_q <= (flicker_irq_enable_q & flicker_change)
        | (matrix_done_irq_enable_q & matrix_done);
    end
  end

  // Sleep control hookup
  assign sl.sleep_on_irq = sleep_on_irq_q;
  assign sl.irq_pending = irq_pending;
  assign sl.flag_clr = irq_sleep_clr;
  assign irq_sleep_flag_q = sl.irq_sleep_flag;
  assign osc_run_q = sl.osc_run;

  mcr_sleep_ctrl u_sleep (
    .clk(clk),
    .rst_n(rst_n),
    .sl(sl.ctrl)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_low_power_entry: assert property (
    low_power_en_q && all_idle && !reg_wr |=> low_power_q)
    else $error("low power not entered while idle");

  chk_page_blocks_write: assert property (
    page_sel_q && reg_wr && reg_addr == mcr_pkg::SYSTEM_IRQ_ENABLES_OFS
    |=> $stable(flicker_irq_enable_q) && access_refused_q)
    else $error("upper register written with lower page selected");

  chk_wait_stretch: assert property (
    wait_stretch_q && !reg_wr |=> wait_cycles_q == {$past(wait_time), 4'h0})
    else $error("wait time not stretched by 16");

  chk_cmd_launch: assert property (
    trig_rise && matrix_cmd_q == mcr_pkg::MCR_CMD_WRITE_CHAIN
    |=> cmd_write_chain_q && !cmd_rom_init_q ##1 !cmd_write_chain_q)
    else $error("write-chain command not launched once");

  chk_cmd_reserved: assert property (
    trig_rise && matrix_cmd_q == mcr_pkg::MCR_CMD_RESERVED
    |=> !cmd_rom_init_q && !cmd_read_chain_q && !cmd_write_chain_q)
    else $error("reserved matrix command launched");

  chk_flicker_irq: assert property (
    flicker_irq_enable_q && flicker_change |=> sys_irq_q)
    else $error("flicker change raised no interrupt");

  chk_done_irq: assert property (
    matrix_done && !flicker_change |=> sys_irq_q == $past(matrix_done_irq_enable_q))
    else $error("matrix done interrupt does not follow its enable");

endmodule : mcr_top

// ### include/mcr_pkg.sv
// Package: offsets, bit positions, reset values and command codes of the config registers
package mcr_pkg;

  // Register offsets, upper page
  localparam logic [7:0] POWER_AND_PAGE_CONFIG_OFS = 8'hBF;
  localparam logic [7:0] SLEEP_ON_IRQ_CONFIG_OFS = 8'hC7;
  localparam logic [7:0] SYSTEM_IRQ_ENABLES_OFS = 8'hCA;
  localparam logic [7:0] MATRIX_COMMAND_CONFIG_OFS = 8'hF5;

  // Page limits
  localparam logic [7:0] LOWER_PAGE_FIRST = 8'h20;
  localparam logic [7:0] LOWER_PAGE_LAST = 8'h7F;
  localparam logic [7:0] UPPER_PAGE_FIRST = 8'h80;

  // Field positions
  localparam int LOW_POWER_BIT = 5;
  localparam int PAGE_SEL_BIT = 4;
  localparam int WAIT_STRETCH_BIT = 2;
  localparam int SLEEP_ON_IRQ_BIT = 4;
  localparam int FLICKER_IRQ_EN_BIT = 6;
  localparam int MATRIX_DONE_IRQ_EN_BIT = 4;
  localparam int MATRIX_CMD_LSB = 3;
  localparam int MATRIX_CMD_MSB = 4;

  // Wait stretch factor of 16 as a shift
  localparam int WAIT_STRETCH_SHIFT = 4;

  // Reset values
  localparam logic [3:0] SLEEP_CFG_LOW_NIBBLE = 4'hC;
  localparam logic [1:0] MATRIX_CMD_RESET = 2'h2;

  // Switch-matrix commands
  typedef enum logic [1:0] {
    MCR_CMD_ROM_INIT = 2'h0,
    MCR_CMD_READ_CHAIN = 2'h1,
    MCR_CMD_WRITE_CHAIN = 2'h2,
    MCR_CMD_RESERVED = 2'h3
  } mcr_cmd_type;

endpackage : mcr_pkg

// ### include/mcr_sleep_if.sv
// Interface: sleep-on-interrupt signals between register bank and sleep control
`timescale 1ns/1ps
interface mcr_sleep_if;
  logic sleep_on_irq;
  logic irq_pending;
  logic flag_clr;
  logic irq_sleep_flag;
  logic osc_run;

  modport ctrl (
    input sleep_on_irq,
    input irq_pending,
    input flag_clr,
    output irq_sleep_flag,
    output osc_run
  );

  modport cfg (
    output sleep_on_irq,
    output irq_pending,
    output flag_clr,
    input irq_sleep_flag,
    input osc_run
  );
endinterface : mcr_sleep_if

// ### design/mcr_sleep_ctrl.sv
// Sleep-after-interrupt control: flag and oscillator gate
`timescale 1ns/1ps
module mcr_sleep_ctrl (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  mcr_sleep_if.ctrl sl // Sleep control signals
);

  logic flag_d;

  // Set wins over clear; clear only sticks once interrupts are gone or sleep-on-interrupt is off
  always_comb begin
    flag_d = (sl.sleep_on_irq & sl.irq_pending) | (sl.irq_sleep_flag & ~sl.flag_clr);
  end

  // Flag and oscillator gate move together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sl.irq_sleep_flag <= 1'b0;
      sl.osc_run <= 1'b1;
    end else begin
      sl.irq_sleep_flag <= flag_d;
      sl.osc_run <= ~flag_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sleep_enter: assert property (
    sl.sleep_on_irq && sl.irq_pending |=> sl.irq_sleep_flag && !sl.osc_run)
    else $error("sleep not entered on pending interrupt");

  chk_sleep_hold: assert property (
    sl.irq_sleep_flag && sl.irq_pending && sl.sleep_on_irq |=> !sl.osc_run)
    else $error("oscillator resumed with interrupt still pending");

  chk_flag_clear: assert property (
    sl.irq_sleep_flag && sl.flag_clr && !sl.irq_pending |=> !sl.irq_sleep_flag ##0 sl.osc_run)
    else $error("clearing flag did not wake the device");

endmodule : mcr_sleep_ctrl

// ### bench/mcr_host.sv
// Host model: drives the register strobes of the config bank
`timescale 1ns/1ps
module mcr_host (
  input wire logic clk, // System clock
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata_q, // Read data
  input wire logic access_refused_q // Refused pulse
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One single-byte access, held until the taking edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic rf);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1;
    q = reg_rdata_q;
    rf = access_refused_q;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a; // Released lines show no stale value
    reg_wdata = ~d;
  endtask : access
endmodule : mcr_host

// ### bench/testbench.sv
// Self-checking bench for the config register bank
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, access_refused_q, page_sel_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, wait_time, flicker_status, q;
  logic all_idle = 1'b0, low_power_q, irq_pending = 1'b0, irq_sleep_clr = 1'b0;
  logic irq_sleep_flag_q, osc_run_q, matrix_command_trigger = 1'b0, rf, sys_irq_q;
  logic cmd_rom_init_q, cmd_read_chain_q, cmd_write_chain_q, matrix_done = 1'b0;
  logic [11:0] wait_cycles_q;
  int n_fail = 0, check_count = 0;
  logic [11:0] cnt [4];

  mcr_host mcr_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .access_refused_q(access_refused_q));
  mcr_top mcr_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .access_refused_q(access_refused_q), .page_sel_q(page_sel_q), .all_idle(all_idle),
    .low_power_q(low_power_q), .wait_time(wait_time), .wait_cycles_q(wait_cycles_q),
    .irq_pending(irq_pending), .irq_sleep_clr(irq_sleep_clr),
    .irq_sleep_flag_q(irq_sleep_flag_q), .osc_run_q(osc_run_q),
    .matrix_command_trigger(matrix_command_trigger), .cmd_rom_init_q(cmd_rom_init_q),
    .cmd_read_chain_q(cmd_read_chain_q), .cmd_write_chain_q(cmd_write_chain_q),
    .matrix_done(matrix_done), .flicker_status(flicker_status), .sys_irq_q(sys_irq_q));

  // 100 ns clock
  always #50 clk = ~clk;

  // Compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Count output pulses over four cycles; event inputs drop after one
  task automatic watch();
    cnt = '{default: 12'h000};
    repeat (4) begin
      @(posedge clk);
      #1;
      cnt[0] += 12'(cmd_rom_init_q === 1'b1);
      cnt[1] += 12'(cmd_read_chain_q === 1'b1);
      cnt[2] += 12'(cmd_write_chain_q === 1'b1);
      cnt[3] += 12'(sys_irq_q === 1'b1);
      matrix_done = 1'b0;
      matrix_command_trigger = 1'b0;
    end
  endtask : watch

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mcr_host_i.access(1'b1, a, d, q, rf);
  endtask : wr

  // Read and compare data and refusal
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic er);
    mcr_host_i.access(1'b0, a, 8'h00, q, rf);
    chk(q, e);
    chk(rf, er);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    wait_time = 8'hAB;
    flicker_status = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(osc_run_q, 1'b1);
    rd(8'hBF, 8'h00, 1'b0);
    rd(8'hC7, 8'h0C, 1'b0);
    rd(8'hCA, 8'h00, 1'b0);
    rd(8'hF5, 8'h10, 1'b0);
    $display("reset test done");
    wr(8'hBF, 8'h20);
    all_idle = 1'b1;
    settle();
    chk(low_power_q, 1'b1);
    chk(wait_cycles_q, 12'h0AB);
    wr(8'hBF, 8'h04);
    settle();
    chk(low_power_q, 1'b0);
    chk(wait_cycles_q, 12'hAB0);
    $display("power test done");
    wr(8'hBF, 8'h14);
    chk(page_sel_q, 1'b1);
    rd(8'hCA, 8'h00, 1'b1);
    wr(8'hCA, 8'h50);
    chk(rf, 1'b1);
    rd(8'h40, 8'h00, 1'b0);
    wr(8'hBF, 8'h04);
    rd(8'h40, 8'h00, 1'b1);
    rd(8'hBF, 8'h04, 1'b0);
    $display("page test done");
    flicker_status = 8'h01;
    watch();
    chk(cnt[3], 0);
    wr(8'hCA, 8'h50);
    rd(8'hCA, 8'h50, 1'b0);
    flicker_status = 8'h03;
    watch();
    chk(cnt[3], 1);
    flicker_status = 8'h07;
    matrix_done = 1'b1;
    watch();
    chk(cnt[3], 1);
    wr(8'hCA, 8'h40);
    matrix_done = 1'b1;
    watch();
    chk(cnt[3], 0);
    $display("interrupt test done");
    for (int c = 0; c < 4; c++) begin
      wr(8'hF5, 8'(c << 3));
      matrix_command_trigger = 1'b1;
      watch();
      chk(cnt[0], c == 0);
      chk(cnt[1], c == 1);
      chk(cnt[2], c == 2);
    end
    $display("matrix test done");
    irq_pending = 1'b1;
    settle();
    chk(irq_sleep_flag_q, 1'b0);
    wr(8'hC7, 8'h1C);
    @(posedge clk);
    #1;
    chk(irq_sleep_flag_q, 1'b1);
    chk(osc_run_q, 1'b0);
    irq_sleep_clr = 1'b1;
    settle();
    irq_sleep_clr = 1'b0;
    chk(irq_sleep_flag_q, 1'b1);
    irq_pending = 1'b0;
    settle();
    chk(osc_run_q, 1'b0);
    irq_sleep_clr = 1'b1;
    @(posedge clk);
    #1;
    irq_sleep_clr = 1'b0;
    @(posedge clk);
    #1;
    chk(irq_sleep_flag_q, 1'b0);
    chk(osc_run_q, 1'b1);
    rd(8'hC7, 8'h1C, 1'b0);
    $display("sleep test done");
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(osc_run_q, 1'b1);
    rd(8'hC7, 8'h0C, 1'b0);
    rd(8'hF5, 8'h10, 1'b0);
    rd(8'hCA, 8'h00, 1'b0);
    $display("second reset test done");
    print_verdict();
  end
endmodule : testbench
